// ---- bench/line_source.sv ----
/* Far-end line model: sends loop-up, loop-down, noise or all ones.
   Assumes the bench changes code only between bits. */
`timescale 1ns/1ps
`default_nettype none
module line_source (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [1:0] code,
    input  wire logic       noise,
    output var  logic       rx_bit,
    output var  logic       rx_valid
);
    logic [2:0] ph;
    logic [3:0] idx;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {ph, idx, rx_bit, rx_valid} <= '0;
        end else begin
            ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            rx_valid <= ph < 3'h3;
            if (ph == 3'h4) begin
                idx <= (idx == 4'he) ? 4'h0 : idx + 4'h1;
                case (code)
                    2'h0: rx_bit <= noise;
                    2'h1: rx_bit <= idx % 5 == 4;
                    2'h2: rx_bit <= idx % 3 == 2;
                    default: rx_bit <= 1'b1;
                endcase
            end
        end
    end
endmodule // line_source
`default_nettype wire

// ---- bench/loop_code_asserts.sv ----
/* Port checker of the loop-code detector.
   Assumes it is bound to every detector instance. */
`timescale 1ns/1ps
`default_nettype none
module loop_code_asserts #(parameter QUAL_CYCLES = 200) (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        remote_loopback,
    input wire logic        irq
);
    wire         wr = hsel && hready && htrans[1] && hwrite;
    wire         rs = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h0c;
    logic        pc, pe, en, lb;
    logic [1:0]  sel;
    logic [31:0] age;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            {pc, pe, en, lb, sel, age} <= '0;
        end else begin
            pc <= wr && haddr[7:0] == 8'h00;
            pe <= wr && haddr[7:0] == 8'h08;
            lb <= remote_loopback;
            if (pc) sel <= hwdata[7:6];
            if (pe) en <= hwdata[3];
            age <= (pc || lb != remote_loopback) ? 32'h0 : age + 32'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_loop_auto: assert property ((sel != 2'h3) [*3] |-> !remote_loopback)
        else $error("loopback outside auto");
    chk_loop_rise: assert property ($rose(remote_loopback) |-> age >= QUAL_CYCLES)
        else $error("loopback too early");
    chk_loop_fall: assert property (
        $fell(remote_loopback) |-> sel != 2'h3 || age >= QUAL_CYCLES)
        else $error("loopback dropped early");
    chk_irq_masked: assert property ((!en) [*3] |-> !irq)
        else $error("irq while disabled");
    chk_irq_raise: assert property ($rose(remote_loopback) && en |-> ##[0:3] irq)
        else $error("no irq on detection");
    chk_irq_clear: assert property (
        $fell(irq) |-> !en || $past(rs) || $past(rs, 2) || $past(rs, 3) || $past(rs, 4))
        else $error("irq dropped without read");
    cover property ($rose(remote_loopback));
    cover property ($fell(remote_loopback) && sel == 2'h3);
    cover property ($fell(irq));
endmodule // loop_code_asserts
bind loop_code_detector loop_code_asserts #(.QUAL_CYCLES(QUAL_CYCLES)) chk_u (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .remote_loopback(remote_loopback), .irq(irq));
`default_nettype wire

// ---- bench/tb.sv ----
/* Self-checking bench of the loop-code detector.
   Assumes the line model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int Q = 120;
    logic        ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, noise = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, r;
    logic [1:0]  htrans = 2'h0, code = 2'h3;
    wire  [31:0] hrdata;
    wire         hreadyout, rx_bit, rx_valid, remote_loopback, irq;
    int          err_count = 0, tests_run = 0, cyc = 0, m, c, i;
    loop_code_detector #(.QUAL_CYCLES(Q)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .rx_bit(rx_bit), .rx_valid(rx_valid),
        .remote_loopback(remote_loopback), .irq(irq));
    line_source src_u (.ref_clk(ref_clk), .resetn(resetn), .code(code), .noise(noise),
        .rx_bit(rx_bit), .rx_valid(rx_valid));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        noise <= 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    function automatic logic exp_flag(input int md, input int cd);
        return (md == 1 && cd == 1) || (md == 2 && cd == 2);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(r & msk, e);
    endtask
    task automatic wait_flag(input logic e);
        i = 0;
        do begin
            bus(1'b0, 8'h04, 32'h0);
            i++;
        end while (r[3] !== e && i < Q);
        chk(r & 32'h8, {28'h0, e, 3'h0});
    endtask
    task automatic wait_lb(input logic e);
        i = 0;
        while (remote_loopback !== e && i < 3 * Q) begin
            @(posedge ref_clk);
            i++;
        end
        chk(remote_loopback, e);
    endtask
    task automatic final_report();
        $display("mismatches %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h8bd49abf));
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        for (i = 0; i < 5; i++) rd(8'(i * 4), 32'hffffffff, 32'h0);
        m = $urandom & 63;
        bus(1'b1, 8'h00, m);
        bus(1'b1, 8'h10, 32'hffffffff);
        rd(8'h00, 32'hff, m);
        rd(8'h10, 32'hffffffff, 32'h0);
        bus(1'b1, 8'h08, 32'h8);
        rd(8'h08, 32'h8, 32'h8);
        for (m = 0; m < 3; m++) begin
            for (c = 1; c < 3; c++) begin
                bus(1'b1, 8'h00, 32'h0);
                code <= 2'h0;
                repeat (12) @(posedge ref_clk);
                bus(1'b0, 8'h0c, 32'h0);
                bus(1'b1, 8'h00, m << 6);
                code <= 2'(c);
                if (exp_flag(m, c)) wait_flag(1'b1);
                else begin
                    repeat (2 * Q) @(posedge ref_clk);
                    rd(8'h04, 32'h8, 32'h0);
                end
                repeat (3) @(posedge ref_clk);
                chk(irq, exp_flag(m, c));
            end
        end
        bus(1'b0, 8'h0c, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b0);
        code <= 2'h3;
        wait_flag(1'b0);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b1);
        bus(1'b1, 8'h08, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b0);
        bus(1'b1, 8'h08, 32'h8);
        rd(8'h0c, 32'h8, 32'h8);
        bus(1'b1, 8'h00, 32'h40);
        code <= 2'h1;
        repeat (Q * 4 / 5) @(posedge ref_clk);
        code <= 2'h3;
        repeat (12) @(posedge ref_clk);
        code <= 2'h1;
        repeat (Q * 4 / 5) @(posedge ref_clk);
        rd(8'h04, 32'h8, 32'h0);
        wait_flag(1'b1);
        bus(1'b1, 8'h00, 32'hc0);
        rd(8'h04, 32'h8, 32'h0);
        wait_flag(1'b1);
        wait_lb(1'b1);
        code <= 2'h0;
        repeat (2 * Q) @(posedge ref_clk);
        rd(8'h04, 32'h8, 32'h8);
        chk(remote_loopback, 1'b1);
        code <= 2'h2;
        wait_lb(1'b0);
        code <= 2'h1;
        wait_lb(1'b1);
        bus(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge ref_clk);
        chk(remote_loopback, 1'b0);
        final_report();
    end
endmodule // tb
`default_nettype wire

// ---- verilog/loop_code_defs.vh ----
/*
 * Register map, field positions and timing constants of the loop-code detector.
 * Assumes a 40 MHz register clock and 32-bit AHB-Lite word access.
 */
`ifndef LOOP_CODE_DEFS_VH
`define LOOP_CODE_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL3     8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_EN    8'h08
`define OFS_IRQ_STAT  8'h0c

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define SEL_HI        7
`define SEL_LO        6
`define FLAG_BIT      3
`define CTRL3_RESET   8'h00
`define MODE_OFF      2'h0
`define MODE_UP       2'h1
`define MODE_DOWN     2'h2
`define MODE_AUTO     2'h3

// ----------------------------------------------------------------------------
// Patterns and timing
// ----------------------------------------------------------------------------
`define UP_PATTERN    5'h01
`define UP_LEN        5
`define DOWN_PATTERN  3'h1
`define DOWN_LEN      3
`define QUAL_SECONDS  5
`define CLK_HZ        40000000

`endif

// ---- verilog/loop_code_detector.v ----
/*
 * Network loop-code detector of one receive channel with an AHB-Lite register slave.
 * Assumes rx_bit/rx_valid come from another clock domain and are synchronised here.
 */
// Decided for this implementation: the address map and the AHB-Lite slave port.
// Behaviour
// - Select field 00, the reset value, turns detection off.
// - Select field 01 searches the receive data for the loop-up code only.
// - Select field 10 searches the receive data for the loop-down code only.
// - Select field 11 runs automatic mode and turns on remote loop-back on loop-up.
// - The loop-up code is the repeating pattern 00001.
// - The loop-down code is the repeating pattern 001.
// - The detected flag, status bit 3, sets once the code has lasted over 5 seconds.
// - A change of the flag with interrupt enable bit 3 high raises the interrupt.
// - Entering automatic mode clears the flag and starts the loop-up search.
// - In automatic mode a loop-up code over 5 seconds sets the flag and loop-back.
// - After loop-back is on, automatic mode searches for the loop-down code.
// - In automatic mode the flag stays set when the loop-up code stops.
// - Loop-back ends only on loop-down over 5 seconds or on leaving automatic mode.
// - With the interrupt enabled, both detection and loss of detection interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "loop_code_defs.vh"

module loop_code_detector #(
    parameter QUAL_CYCLES = `QUAL_SECONDS * `CLK_HZ + 1
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        rx_bit,
    input  wire        rx_valid,
    output reg         remote_loopback,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    reg [1:0] bit_sync_reg;
    reg [1:0] vld_sync_reg;
    reg       vld_last_reg;
    wire      rx_strobe = vld_sync_reg[1] & ~vld_last_reg;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bit_sync_reg <= 2'h0;
            vld_sync_reg <= 2'h0;
            vld_last_reg <= 1'b0;
        end else begin
            bit_sync_reg <= {bit_sync_reg[0], rx_bit};
            vld_sync_reg <= {vld_sync_reg[0], rx_valid};
            vld_last_reg <= vld_sync_reg[1];
        end
    end

    // ------------------------------------------------------------------------
    // Pattern matchers
    // ------------------------------------------------------------------------
    wire up_match;
    wire up_miss;
    wire down_match;
    wire down_miss;

    pattern_match #(.LEN(`UP_LEN)) u_up (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (rx_strobe),
        .in_bit    (bit_sync_reg[1]),
        .pattern   (`UP_PATTERN),
        .match_reg (up_match),
        .miss_reg  (up_miss)
    );

    pattern_match #(.LEN(`DOWN_LEN)) u_down (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .in_valid  (rx_strobe),
        .in_bit    (bit_sync_reg[1]),
        .pattern   (`DOWN_PATTERN),
        .match_reg (down_match),
        .miss_reg  (down_miss)
    );

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [7:0]  ctrl3_reg;
    reg         flag_reg;
    reg         irq_en_reg;
    reg         irq_stat_reg;
    reg  [31:0] qual_cnt_reg;
    reg         qualified_reg;
    reg  [1:0]  mode_last_reg;
    wire [1:0]  mode = ctrl3_reg[`SEL_HI:`SEL_LO];
    reg         flag_next;
    reg         loop_next;

    // Which code is being searched in the current mode.
    reg want_down;
    reg searching;
    always @* begin
        want_down = 1'b0;
        searching = 1'b1;
        case (mode)
            `MODE_OFF:  searching = 1'b0;
            `MODE_UP:   want_down = 1'b0;
            `MODE_DOWN: want_down = 1'b1;
            `MODE_AUTO: want_down = remote_loopback;
            default:    searching = 1'b0;
        endcase
    end

    wire cur_match = want_down ? down_match : up_match;
    wire cur_miss  = want_down ? down_miss  : up_miss;
    wire entering_auto = (mode == `MODE_AUTO) && (mode_last_reg != `MODE_AUTO);

    // ------------------------------------------------------------------------
    // Qualification timer
    // ------------------------------------------------------------------------
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            qual_cnt_reg  <= 32'h0;
            qualified_reg <= 1'b0;
            mode_last_reg <= `MODE_OFF;
        end else begin
            mode_last_reg <= mode;
            // A mode change or a loop-back change switches the searched code,
            // so the old qualification must not carry over to the new code.
            if (!searching || cur_miss || (mode != mode_last_reg)
                || (loop_next != remote_loopback)) begin
                qual_cnt_reg  <= 32'h0;
                qualified_reg <= 1'b0;
            end else if (cur_match || qual_cnt_reg != 32'h0) begin
                if (qual_cnt_reg >= QUAL_CYCLES[31:0]) begin
                    qualified_reg <= 1'b1;
                end else begin
                    qual_cnt_reg <= qual_cnt_reg + 32'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Flag and loop-back
    // ------------------------------------------------------------------------
    always @* begin
        flag_next = flag_reg;
        loop_next = remote_loopback;
        if (mode != `MODE_AUTO) begin
            loop_next = 1'b0;
            flag_next = qualified_reg;
        end else if (entering_auto) begin
            flag_next = 1'b0;
        end else if (qualified_reg && !remote_loopback) begin
            flag_next = 1'b1;
            loop_next = 1'b1;
        end else if (qualified_reg && remote_loopback && want_down) begin
            loop_next = 1'b0;
            flag_next = 1'b0;
        end
        // In automatic mode, loss of loop-up code alone leaves the flag set.
    end

    wire flag_change = flag_next != flag_reg;

    // ------------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------------
    reg        wr_pend_reg;
    reg [7:0]  addr_reg;
    wire       take = hsel && hready && htrans[1];
    wire [7:0] raddr = haddr[7:0];
    wire       rd_irq = take && !hwrite && (raddr == `OFS_IRQ_STAT);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg     <= 1'b0;
            addr_reg        <= 8'h00;
            hrdata          <= 32'h0;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
            ctrl3_reg       <= `CTRL3_RESET;
            irq_en_reg      <= 1'b0;
            irq_stat_reg    <= 1'b0;
            flag_reg        <= 1'b0;
            remote_loopback <= 1'b0;
            irq             <= 1'b0;
        end else begin
            flag_reg        <= flag_next;
            remote_loopback <= loop_next;
            wr_pend_reg     <= take && hwrite;
            if (take) begin
                addr_reg <= raddr;
            end
            if (wr_pend_reg) begin
                case (addr_reg)
                    `OFS_CTRL3:  ctrl3_reg  <= hwdata[7:0];
                    `OFS_IRQ_EN: irq_en_reg <= hwdata[`FLAG_BIT];
                    default:     ctrl3_reg  <= ctrl3_reg;
                endcase
            end
            if (take && !hwrite) begin
                case (raddr)
                    `OFS_CTRL3:    hrdata <= {24'h0, ctrl3_reg};
                    `OFS_STATUS:   hrdata <= {28'h0, flag_reg, 3'h0};
                    `OFS_IRQ_EN:   hrdata <= {28'h0, irq_en_reg, 3'h0};
                    `OFS_IRQ_STAT: hrdata <= {28'h0, irq_stat_reg, 3'h0};
                    default:       hrdata <= 32'h0;
                endcase
            end
            // A change in the same cycle as the clearing read wins.
            if (flag_change) begin
                irq_stat_reg <= 1'b1;
            end else if (rd_irq) begin
                irq_stat_reg <= 1'b0;
            end
            irq <= irq_en_reg && (flag_change || (irq_stat_reg && !rd_irq));
        end
    end

endmodule // loop_code_detector

`default_nettype wire

// ---- verilog/pattern_match.v ----
/*
 * Checks that the received bit stream repeats a fixed pattern.
 * Assumes one received bit per in_valid pulse on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "loop_code_defs.vh"

module pattern_match #(
    parameter LEN = 5
) (
    input  wire           ref_clk,
    input  wire           resetn,
    input  wire           in_valid,
    input  wire           in_bit,
    input  wire [LEN-1:0] pattern,
    output reg            match_reg,
    output reg            miss_reg
);

    reg [LEN-1:0] hist_reg;
    wire [LEN-1:0] hist_next = {hist_reg[LEN-2:0], in_bit};
    wire           expect_bit = hist_reg[LEN-1];

    // A repeating pattern means each bit equals the bit LEN places earlier,
    // provided the history itself is one rotation of the pattern.
    wire           is_rot;
    genvar i;
    wire [LEN-1:0] rot_hit;
    generate
        for (i = 0; i < LEN; i = i + 1) begin : g_rot
            assign rot_hit[i] = (hist_next == ((pattern << i) | (pattern >> (LEN - i))));
        end
    endgenerate
    assign is_rot = |rot_hit;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hist_reg  <= {LEN{1'b0}};
            match_reg <= 1'b0;
            miss_reg  <= 1'b0;
        end else begin
            miss_reg <= 1'b0;
            if (in_valid) begin
                hist_reg  <= hist_next;
                match_reg <= is_rot && (in_bit == expect_bit);
                miss_reg  <= !(is_rot && (in_bit == expect_bit));
            end
        end
    end

endmodule // pattern_match

`default_nettype wire
